// [hw/bfe_cfg.svh]
// constants for the branch / bit / flag execution slice
`ifndef BFE_CFG_SVH
`define BFE_CFG_SVH

// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define BFE_SR_C 0
`define BFE_SR_Z 1
`define BFE_SR_N 2
`define BFE_SR_V 3
`define BFE_SR_S 4
`define BFE_SR_H 5
`define BFE_SR_T 6
`define BFE_SR_I 7

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define BFE_PC_W        12
`define BFE_SR_RESET    8'h00
`define BFE_PC_RESET    12'h000
`define BFE_BYTE_RESET  8'h00

// ----------------------------------------
// io space and peek port map
// ----------------------------------------
`define BFE_IO_BIT_TOP  6'h1F
`define BFE_PEEK_IO_SEL 6
`define BFE_PEEK_RF_TOP 7'h1F

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define BFE_CYC_SHORT   1
`define BFE_CYC_LONG    2

`endif

// [hw/bfe_pkg.sv]
// types for the branch / bit / flag execution slice
package bfe_pkg;

  // ----------------------------------------
  // decoded operations
  // ----------------------------------------
  typedef enum logic [5:0] {
    OP_NOP,
    OP_BR_SAME_HIGH, OP_BR_LOWER, OP_BR_NEG, OP_BR_POS, OP_BR_SGE, OP_BR_SLT,
    OP_BR_HALF_ON, OP_BR_HALF_OFF, OP_BR_XFER_ON, OP_BR_XFER_OFF,
    OP_BR_OVF_ON, OP_BR_OVF_OFF, OP_BR_IRQ_ON, OP_BR_IRQ_OFF,
    OP_IO_BIT_SET, OP_IO_BIT_CLR,
    OP_SHL, OP_SHR, OP_SHR_ARITH, OP_ROT_LEFT, OP_ROT_RIGHT, OP_NIB_SWAP,
    OP_FLAG_ONE, OP_FLAG_ZERO, OP_BIT_TO_XFER, OP_XFER_TO_BIT,
    OP_CARRY_ONE, OP_CARRY_ZERO, OP_NEG_ONE, OP_NEG_ZERO, OP_ZERO_ONE, OP_ZERO_ZERO,
    OP_SIGN_ONE, OP_SIGN_ZERO, OP_OVF_ONE, OP_OVF_ZERO, OP_XFER_ONE, OP_XFER_ZERO,
    OP_HALF_ONE, OP_HALF_ZERO, OP_IRQ_ON, OP_IRQ_OFF
  } bfe_op_t;

  // ----------------------------------------
  // instruction word as handed in by the decoder
  // ----------------------------------------
  typedef struct packed {
    bfe_op_t     op;
    logic [4:0]  rd;
    logic [2:0]  bit_sel;
    logic [5:0]  io_addr;
    logic [6:0]  offset;
  } bfe_instr_t;

  // ----------------------------------------
  // shifter answer
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       zero;
    logic       neg;
    logic       ovf;
  } bfe_shift_res_t;

endpackage

// [hw/bfe_shift_unit.sv]
// combinational shift, rotate and nibble swap of one byte
`include "bfe_cfg.svh"

module bfe_shift_unit
  import bfe_pkg::*;
(
  input  wire bfe_op_t        op,
  input  wire logic [7:0]     operand,
  input  wire logic           carry_in,
  output bfe_shift_res_t      res
);

  // ----------------------------------------
  // result and flags
  // ----------------------------------------
  always_comb begin
    res = '0;
    case (op)
      OP_SHL: begin
        res.result = {operand[6:0], 1'b0}; // [RULE8]
        res.carry  = operand[7];
      end
      OP_SHR: begin
        res.result = {1'b0, operand[7:1]}; // [RULE8]
        res.carry  = operand[0];
      end
      OP_SHR_ARITH: begin
        res.result = {operand[7], operand[7:1]}; // [RULE8]
        res.carry  = operand[0];
      end
      OP_ROT_LEFT: begin
        res.result = {operand[6:0], carry_in}; // [RULE9]
        res.carry  = operand[7];
      end
      OP_ROT_RIGHT: begin
        res.result = {carry_in, operand[7:1]}; // [RULE9]
        res.carry  = operand[0];
      end
      OP_NIB_SWAP: begin
        res.result = {operand[3:0], operand[7:4]}; // [RULE16]
        res.carry  = carry_in;
      end
      default: begin
        res.result = operand;
        res.carry  = carry_in;
      end
    endcase
    res.zero = (res.result == 8'h00);
    res.neg  = res.result[7];
    // overflow here is neg xor carry, as for every shift in this family
    res.ovf  = res.result[7] ^ res.carry;
  end

endmodule

// [hw/bfe_exec.sv]
// execution slice: flag branches, io bit ops, shifts, bit transfer, flag set/clear
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`include "bfe_cfg.svh"

// Function
// [RULE1] Branches keep all flags, take 1 or 2 cycles, test carry clear or set, and jump to pc plus offset plus 1.
// [RULE2] Minus and plus follow the negative flag, signed ge and less follow negative xor overflow being 0 or 1.
// [RULE3] The half-carry branch pair is taken on half carry 1 or 0 with the usual relative target.
// [RULE4] The transfer-flag branch pair is taken on the transfer bit set or cleared with the usual relative target.
// [RULE5] The overflow branch pair is taken on overflow set or clear with the usual relative target.
// [RULE6] The interrupt branch pair is taken on global interrupt enable 1 or 0 with the usual target and timing.
// [RULE7] The io bit ops force one chosen bit of an io register to 1 or 0, take 2 cycles and touch no flag.
// [RULE8] Logic shifts fill with zero, arithmetic right shift keeps bit 7, each in 1 cycle, setting Z, C, N and V.
// [RULE9] Rotates go through carry in either direction in 1 cycle and update zero, carry, negative and overflow.
// [RULE10] Bit store copies a register bit to the transfer flag, bit load copies it back, no flag moves, 1 cycle each.
// [RULE11] Generic and dedicated flag set and clear ops write one status bit only, in 1 cycle.
// [RULE12] Interrupt enable sets and interrupt disable clears the global enable bit in one cycle.
// [RULE13] Io bit ops reach only io addresses 0x00 to 0x1F.
// [RULE14] An io bit op changes only the addressed bit, so neighbouring flags in that register stay as they are.
// [RULE15] A branch not taken finishes in one cycle, a taken one in two with the next fetch thrown away.
// [RULE16] Nibble swap exchanges the two halves of a register in one cycle and touches no flag.
module bfe_exec
  import bfe_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  instr_valid,
  input  wire bfe_instr_t            instr,
  output logic                       instr_ready,
  output logic                       done,
  output logic                       fetch_flush,
  output logic [`BFE_PC_W-1:0]       pc,
  output logic [7:0]                 status_register,
  input  wire logic [6:0]            peek_addr,
  input  wire logic [7:0]            peek_wdata,
  input  wire logic                  peek_wr,
  input  wire logic                  peek_rd,
  output logic [7:0]                 peek_rdata
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_branch(input bfe_op_t op);
    return (op >= OP_BR_SAME_HIGH) && (op <= OP_BR_IRQ_OFF);
  endfunction

  function automatic logic br_cond(input bfe_op_t op, input logic [7:0] sr);
    case (op)
      OP_BR_SAME_HIGH: br_cond = !sr[`BFE_SR_C]; // [RULE1]
      OP_BR_LOWER:     br_cond =  sr[`BFE_SR_C]; // [RULE1]
      OP_BR_NEG:       br_cond =  sr[`BFE_SR_N]; // [RULE2]
      OP_BR_POS:       br_cond = !sr[`BFE_SR_N]; // [RULE2]
      OP_BR_SGE:       br_cond = (sr[`BFE_SR_N] ^ sr[`BFE_SR_V]) == 1'b0; // [RULE2]
      OP_BR_SLT:       br_cond = (sr[`BFE_SR_N] ^ sr[`BFE_SR_V]) == 1'b1; // [RULE2]
      OP_BR_HALF_ON:   br_cond =  sr[`BFE_SR_H]; // [RULE3]
      OP_BR_HALF_OFF:  br_cond = !sr[`BFE_SR_H]; // [RULE3]
      OP_BR_XFER_ON:   br_cond =  sr[`BFE_SR_T]; // [RULE4]
      OP_BR_XFER_OFF:  br_cond = !sr[`BFE_SR_T]; // [RULE4]
      OP_BR_OVF_ON:    br_cond =  sr[`BFE_SR_V]; // [RULE5]
      OP_BR_OVF_OFF:   br_cond = !sr[`BFE_SR_V]; // [RULE5]
      OP_BR_IRQ_ON:    br_cond =  sr[`BFE_SR_I]; // [RULE6]
      OP_BR_IRQ_OFF:   br_cond = !sr[`BFE_SR_I]; // [RULE6]
      default:         br_cond = 1'b0;
    endcase
  endfunction

  function automatic logic is_io_op(input bfe_op_t op);
    return (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLR);
  endfunction

  function automatic logic is_shift(input bfe_op_t op);
    return (op >= OP_SHL) && (op <= OP_ROT_RIGHT);
  endfunction

  // {hit, value, index}: one status bit to force, or none
  function automatic logic [4:0] flag_force(input bfe_op_t op, input logic [2:0] sel);
    case (op)
      OP_FLAG_ONE:   flag_force = {2'b11, sel}; // [RULE11]
      OP_FLAG_ZERO:  flag_force = {2'b10, sel}; // [RULE11]
      OP_CARRY_ONE:  flag_force = {2'b11, 3'(`BFE_SR_C)};
      OP_CARRY_ZERO: flag_force = {2'b10, 3'(`BFE_SR_C)};
      OP_NEG_ONE:    flag_force = {2'b11, 3'(`BFE_SR_N)};
      OP_NEG_ZERO:   flag_force = {2'b10, 3'(`BFE_SR_N)};
      OP_ZERO_ONE:   flag_force = {2'b11, 3'(`BFE_SR_Z)};
      OP_ZERO_ZERO:  flag_force = {2'b10, 3'(`BFE_SR_Z)};
      OP_SIGN_ONE:   flag_force = {2'b11, 3'(`BFE_SR_S)};
      OP_SIGN_ZERO:  flag_force = {2'b10, 3'(`BFE_SR_S)};
      OP_OVF_ONE:    flag_force = {2'b11, 3'(`BFE_SR_V)};
      OP_OVF_ZERO:   flag_force = {2'b10, 3'(`BFE_SR_V)};
      OP_XFER_ONE:   flag_force = {2'b11, 3'(`BFE_SR_T)};
      OP_XFER_ZERO:  flag_force = {2'b10, 3'(`BFE_SR_T)};
      OP_HALF_ONE:   flag_force = {2'b11, 3'(`BFE_SR_H)};
      OP_HALF_ZERO:  flag_force = {2'b10, 3'(`BFE_SR_H)};
      OP_IRQ_ON:     flag_force = {2'b11, 3'(`BFE_SR_I)}; // [RULE12]
      OP_IRQ_OFF:    flag_force = {2'b10, 3'(`BFE_SR_I)}; // [RULE12]
      default:       flag_force = 5'h00;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic {ST_EXEC, ST_SECOND} bfe_state_t;

  bfe_state_t            state_q;
  bfe_instr_t            held_q;
  logic                  ready_q;
  logic                  done_q;
  logic                  flush_q;
  logic [`BFE_PC_W-1:0]  pc_q;
  logic [7:0]            sr_q;
  logic [7:0]            peek_q;
  logic [7:0]            regs_q [32];
  logic [7:0]            io_q [64];

  logic                  take;
  logic                  long_op;
  logic                  finish;
  logic [7:0]            operand;
  logic [4:0]            force_w;
  logic [`BFE_PC_W-1:0]  pc_next_seq;
  logic [`BFE_PC_W-1:0]  pc_target;
  logic                  io_in_range;
  bfe_shift_res_t        sh;

  assign instr_ready     = ready_q;
  assign done            = done_q;
  assign fetch_flush     = flush_q;
  assign pc              = pc_q;
  assign status_register = sr_q;
  assign peek_rdata      = peek_q;

  // ----------------------------------------
  // issue decode
  // ----------------------------------------
  assign take    = instr_valid && ready_q;
  // taken branches and io bit ops need a second cycle
  assign long_op = is_io_op(instr.op) || (is_branch(instr.op) && br_cond(instr.op, sr_q)); // [RULE15] [RULE7]
  assign finish  = (take && !long_op) || (state_q == ST_SECOND);
  assign operand = regs_q[instr.rd];
  assign force_w = flag_force(instr.op, instr.bit_sel);
  assign pc_next_seq = pc_q + `BFE_PC_W'(1);
  // condition and target are latched at issue, so flags cannot move under it
  assign pc_target   = pc_q + `BFE_PC_W'(signed'(instr.offset)) + `BFE_PC_W'(1); // [RULE1]
  assign io_in_range = (held_q.io_addr <= `BFE_IO_BIT_TOP); // [RULE13]

  bfe_shift_unit u_shift (
    .op       (instr.op),
    .operand  (operand),
    .carry_in (sr_q[`BFE_SR_C]),
    .res      (sh)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_EXEC;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
      flush_q <= 1'b0;
      held_q  <= '0;
    end else begin
      done_q  <= finish;
      flush_q <= 1'b0;
      case (state_q)
        ST_EXEC: begin
          ready_q <= 1'b1;
          if (take && long_op) begin
            state_q <= ST_SECOND;
            ready_q <= 1'b0;
            held_q  <= instr;
          end
        end
        ST_SECOND: begin
          state_q <= ST_EXEC;
          ready_q <= 1'b1;
          flush_q <= is_branch(held_q.op); // [RULE15]
        end
        default: begin
          state_q <= ST_EXEC;
        end
      endcase
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  logic [`BFE_PC_W-1:0] target_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      target_q <= `BFE_PC_RESET;
    end else if (take) begin
      target_q <= pc_target;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc_q <= `BFE_PC_RESET;
    end else if (state_q == ST_SECOND) begin
      pc_q <= is_branch(held_q.op) ? target_q : pc_next_seq; // [RULE1]
    end else if (take && !long_op) begin
      pc_q <= pc_next_seq; // [RULE15]
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sr_q <= `BFE_SR_RESET;
    end else if (take) begin
      if (is_shift(instr.op)) begin
        // sign flag is not in the updated set and stays put
        sr_q[`BFE_SR_C] <= sh.carry; // [RULE8] [RULE9]
        sr_q[`BFE_SR_Z] <= sh.zero;
        sr_q[`BFE_SR_N] <= sh.neg;
        sr_q[`BFE_SR_V] <= sh.ovf;
      end else if (instr.op == OP_BIT_TO_XFER) begin
        sr_q[`BFE_SR_T] <= operand[instr.bit_sel]; // [RULE10]
      end else if (force_w[4]) begin
        sr_q[force_w[2:0]] <= force_w[3]; // [RULE11] [RULE12]
      end
    end
  end

  // ----------------------------------------
  // working registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= `BFE_BYTE_RESET;
      end
    end else if (take && (is_shift(instr.op) || instr.op == OP_NIB_SWAP)) begin
      regs_q[instr.rd] <= sh.result; // [RULE8] [RULE9] [RULE16]
    end else if (take && instr.op == OP_XFER_TO_BIT) begin
      regs_q[instr.rd][instr.bit_sel] <= sr_q[`BFE_SR_T]; // [RULE10]
    end else if (peek_wr && !peek_addr[`BFE_PEEK_IO_SEL] && peek_addr <= `BFE_PEEK_RF_TOP) begin
      regs_q[peek_addr[4:0]] <= peek_wdata;
    end
  end

  // ----------------------------------------
  // io space
  // ----------------------------------------
  // single-bit write, never read-modify-write of the whole byte,
  // so write-one-to-clear neighbours are never hit by accident
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 64; i++) begin
        io_q[i] <= `BFE_BYTE_RESET;
      end
    end else if (state_q == ST_SECOND && is_io_op(held_q.op) && io_in_range) begin
      io_q[held_q.io_addr][held_q.bit_sel] <= (held_q.op == OP_IO_BIT_SET); // [RULE7] [RULE14]
    end else if (peek_wr && peek_addr[`BFE_PEEK_IO_SEL]) begin
      io_q[peek_addr[5:0]] <= peek_wdata;
    end
  end

  // ----------------------------------------
  // peek read port
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      peek_q <= `BFE_BYTE_RESET;
    end else if (!peek_rd) begin
      peek_q <= `BFE_BYTE_RESET;
    end else if (peek_addr[`BFE_PEEK_IO_SEL]) begin
      peek_q <= io_q[peek_addr[5:0]];
    end else if (peek_addr <= `BFE_PEEK_RF_TOP) begin
      peek_q <= regs_q[peek_addr[4:0]];
    end else begin
      peek_q <= `BFE_BYTE_RESET;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic [7:0] io_word;
  assign io_word = io_q[held_q.io_addr];

  // second cycle only checked for a taken branch: an untaken one may be followed at once
  AST_BR_FLAGS_KEPT: assert property (take && is_branch(instr.op) // [RULE1]
    |=> $stable(sr_q) ##1 ($past(state_q) == ST_EXEC || $stable(sr_q)))
    else $error("branch changed a status flag");

  AST_BR_TAKEN_TARGET: assert property ( // [RULE15]
    take && is_branch(instr.op) && br_cond(instr.op, sr_q)
    |=> !ready_q ##1 (pc_q == $past(pc_target, 2)) && flush_q && done_q && ready_q)
    else $error("taken branch target or timing wrong");

  AST_BR_NOT_TAKEN: assert property ( // [RULE15]
    take && is_branch(instr.op) && !br_cond(instr.op, sr_q)
    |=> pc_q == $past(pc_q) + `BFE_PC_W'(1) && done_q && ready_q && !flush_q)
    else $error("untaken branch not one cycle");

  AST_IO_TWO_CYCLES: assert property (take && is_io_op(instr.op) |=> !ready_q ##1 ready_q && done_q) // [RULE7]
    else $error("io bit op not two cycles");

  AST_IO_ONE_BIT: assert property ( // [RULE14]
    state_q == ST_SECOND && is_io_op(held_q.op) && io_in_range && !peek_wr
    |=> io_word == (held_q.op == OP_IO_BIT_SET ? ($past(io_word) | (8'h01 << held_q.bit_sel))
                                              : ($past(io_word) & ~(8'h01 << held_q.bit_sel))))
    else $error("io bit op touched other bits");

  AST_IO_HIGH_BLOCKED: assert property ( // [RULE13]
    state_q == ST_SECOND && is_io_op(held_q.op) && !io_in_range && !peek_wr |=> $stable(io_word))
    else $error("io bit op reached high io space");

  AST_SHIFT_FLAGS: assert property (take && instr.op == OP_SHL // [RULE8]
    |=> sr_q[`BFE_SR_C] == $past(operand[7]) && sr_q[`BFE_SR_Z] == ($past(operand[6:0]) == 7'h00))
    else $error("left shift flags wrong");

  AST_ROT_RIGHT_CARRY: assert property (take && instr.op == OP_ROT_RIGHT // [RULE9]
    |=> sr_q[`BFE_SR_C] == $past(operand[0]) && sr_q[`BFE_SR_N] == $past(sr_q[`BFE_SR_C]))
    else $error("right rotate through carry wrong");

  AST_XFER_STORE: assert property (take && instr.op == OP_BIT_TO_XFER // [RULE10]
    |=> sr_q[`BFE_SR_T] == $past(operand[instr.bit_sel]) && sr_q[5:0] == $past(sr_q[5:0]))
    else $error("bit store into transfer flag wrong");

  AST_IRQ_ENABLE: assert property (take && instr.op == OP_IRQ_ON // [RULE12]
    |=> sr_q[`BFE_SR_I] && sr_q[6:0] == $past(sr_q[6:0]) && done_q)
    else $error("interrupt enable not applied");

  AST_SWAP_NO_FLAGS: assert property (take && instr.op == OP_NIB_SWAP |=> $stable(sr_q) && done_q) // [RULE16]
    else $error("nibble swap changed flags");

  COV_BR_TAKEN: cover property (take && is_branch(instr.op) && br_cond(instr.op, sr_q) ##2 take);
  COV_IO_SET: cover property (take && instr.op == OP_IO_BIT_SET ##1 state_q == ST_SECOND);
  COV_ROT_LEFT: cover property (take && instr.op == OP_ROT_LEFT ##1 done_q);

endmodule

// [dv/branch_bit_flag_exec_bench.sv]
// self-checking bench for the branch / bit / flag execution slice
`include "bfe_cfg.svh"

`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", name, exp, got); end end

module branch_bit_flag_exec_bench
  import bfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // signals and tables
  // ----------------------------------------
  logic                  ref_clk;
  logic                  resetn;
  logic                  instr_valid;
  bfe_instr_t            instr;
  logic                  instr_ready;
  logic                  done;
  logic                  fetch_flush;
  logic [`BFE_PC_W-1:0]  pc;
  logic [7:0]            status_register;
  logic [6:0]            peek_addr;
  logic [7:0]            peek_wdata;
  logic                  peek_wr;
  logic                  peek_rd;
  logic [7:0]            peek_rdata;
  int                    bad_count;
  int                    num_checks;
  logic [`BFE_PC_W-1:0]  exp_pc;
  logic [7:0]            exp_sr;
  logic [7:0]            rd_val;

  bfe_op_t br_ops [12] = '{OP_BR_SAME_HIGH, OP_BR_LOWER, OP_BR_NEG, OP_BR_POS, OP_BR_HALF_ON, OP_BR_HALF_OFF,
                           OP_BR_XFER_ON, OP_BR_XFER_OFF, OP_BR_OVF_ON, OP_BR_OVF_OFF, OP_BR_IRQ_ON, OP_BR_IRQ_OFF};
  int      br_bit [12] = '{0, 0, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7};
  logic [11:0] br_pol = 12'h556;
  bfe_op_t f_one [8]  = '{OP_CARRY_ONE, OP_NEG_ONE, OP_ZERO_ONE, OP_SIGN_ONE, OP_OVF_ONE, OP_XFER_ONE,
                          OP_HALF_ONE, OP_IRQ_ON};
  bfe_op_t f_zero [8] = '{OP_CARRY_ZERO, OP_NEG_ZERO, OP_ZERO_ZERO, OP_SIGN_ZERO, OP_OVF_ZERO, OP_XFER_ZERO,
                          OP_HALF_ZERO, OP_IRQ_OFF};
  int      f_bit [8]  = '{0, 2, 1, 4, 3, 6, 5, 7};
  bfe_op_t sh_ops [6] = '{OP_SHL, OP_SHR, OP_SHR_ARITH, OP_ROT_LEFT, OP_ROT_RIGHT, OP_NIB_SWAP};
  logic [7:0] sh_val [3] = '{8'h81, 8'h01, 8'h80};

  bfe_exec bfe_exec_inst (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .instr_valid     (instr_valid),
    .instr           (instr),
    .instr_ready     (instr_ready),
    .done            (done),
    .fetch_flush     (fetch_flush),
    .pc              (pc),
    .status_register (status_register),
    .peek_addr       (peek_addr),
    .peek_wdata      (peek_wdata),
    .peek_wr         (peek_wr),
    .peek_rd         (peek_rd),
    .peek_rdata      (peek_rdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // shared bus and instruction tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // kind: 0 one cycle, 1 io bit op, 2 taken branch
  task automatic run_op(input bfe_op_t op, input logic [4:0] rd, input logic [2:0] b, input logic [5:0] io,
                        input logic [6:0] off, input int kind);
    int n;
    logic rdy1;
    n = 0;
    rdy1 = 1'b0;
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr       <= '{op: op, rd: rd, bit_sel: b, io_addr: io, offset: off};
    @(negedge ref_clk);
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (n == 1) rdy1 = instr_ready;
    end while (done !== 1'b1 && n < 10);
    `CHK("cycles", (kind == 0) ? `BFE_CYC_SHORT : `BFE_CYC_LONG, n)
    `CHK("ready", (kind == 0), rdy1)
    `CHK("ready again", 1'b1, instr_ready)
    `CHK("flush", (kind == 2), fetch_flush)
    exp_pc = (kind == 2) ? exp_pc + {{(`BFE_PC_W-7){off[6]}}, off} + 1'b1 : exp_pc + 1'b1;
    `CHK("pc", exp_pc, pc)
    `CHK("status", exp_sr, status_register)
  endtask

  task automatic set_flag(input int bitn, input logic v);
    exp_sr[bitn] = v;
    run_op(v ? OP_FLAG_ONE : OP_FLAG_ZERO, 5'h00, bitn[2:0], 6'h00, 7'h00, 0);
  endtask

  task automatic pk_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    peek_addr  <= a;
    peek_wdata <= d;
    peek_wr    <= 1'b1;
    @(posedge ref_clk);
    peek_wr    <= 1'b0;
  endtask

  task automatic pk_rd(input logic [6:0] a);
    @(posedge ref_clk);
    peek_addr <= a;
    peek_rd   <= 1'b1;
    @(posedge ref_clk);
    peek_rd   <= 1'b0;
    @(negedge ref_clk);
    rd_val = peek_rdata;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_flags();
    for (int i = 0; i < 8; i++) begin
      exp_sr[f_bit[i]] = 1'b1;
      run_op(f_one[i], 5'h00, 3'h0, 6'h00, 7'h00, 0);
    end
    for (int i = 0; i < 8; i += 2) begin
      exp_sr[f_bit[i]] = 1'b0;
      run_op(f_zero[i], 5'h00, 3'h0, 6'h00, 7'h00, 0);
    end
    for (int i = 1; i < 8; i += 2) begin
      exp_sr[f_bit[i]] = 1'b0;
      run_op(f_zero[i], 5'h00, 3'h0, 6'h00, 7'h00, 0);
    end
  endtask

  // negative offsets check backward targets; pc stays well above 0, so the 12-bit wrap is never reached
  task automatic t_branch();
    logic tk;
    logic [6:0] off;
    for (int i = 0; i < 12; i++) begin
      for (int v = 0; v < 2; v++) begin
        set_flag(br_bit[i], v[0]);
        tk = (v[0] == br_pol[i]);
        off = i[0] ? 7'h7E : 7'h05;
        run_op(br_ops[i], 5'h00, 3'h0, 6'h00, off, tk ? 2 : 0);
      end
    end
    for (int nv = 0; nv < 4; nv++) begin
      set_flag(`BFE_SR_N, nv[1]);
      set_flag(`BFE_SR_V, nv[0]);
      run_op(OP_BR_SGE, 5'h00, 3'h0, 6'h00, 7'h7C, (nv[1] ^ nv[0]) ? 0 : 2);
      run_op(OP_BR_SLT, 5'h00, 3'h0, 6'h00, 7'h03, (nv[1] ^ nv[0]) ? 2 : 0);
    end
  endtask

  task automatic t_io();
    pk_wr(7'h45, 8'hA5);
    run_op(OP_IO_BIT_SET, 5'h00, 3'h1, 6'h05, 7'h00, 1);
    pk_rd(7'h45);
    `CHK("io5 set", 8'hA7, rd_val)
    run_op(OP_IO_BIT_CLR, 5'h00, 3'h7, 6'h05, 7'h00, 1);
    pk_rd(7'h45);
    `CHK("io5 clear", 8'h27, rd_val)
    pk_wr(7'h5F, 8'h80);
    run_op(OP_IO_BIT_SET, 5'h00, 3'h0, 6'h1F, 7'h00, 1);
    pk_rd(7'h5F);
    `CHK("io1f set", 8'h81, rd_val)
    pk_wr(7'h60, 8'h00);
    run_op(OP_IO_BIT_SET, 5'h00, 3'h3, 6'h20, 7'h00, 1);
    pk_rd(7'h60);
    `CHK("io20 untouched", 8'h00, rd_val)
    pk_rd(7'h20);
    `CHK("unmapped read", 8'h00, rd_val)
  endtask

  // shift results and flags worked out here, not taken from the design
  task automatic t_shift();
    logic [8:0] r;
    logic [7:0] a;
    for (int o = 0; o < 6; o++) begin
      for (int k = 0; k < 6; k++) begin
        a = sh_val[k / 2];
        pk_wr(7'h03, a);
        set_flag(`BFE_SR_C, k[0]);
        case (sh_ops[o])
          OP_SHL:       r = {a[7], a[6:0], 1'b0};
          OP_SHR:       r = {a[0], 1'b0, a[7:1]};
          OP_SHR_ARITH: r = {a[0], a[7], a[7:1]};
          OP_ROT_LEFT:  r = {a[7], a[6:0], k[0]};
          OP_ROT_RIGHT: r = {a[0], k[0], a[7:1]};
          default:      r = {k[0], a[3:0], a[7:4]};
        endcase
        if (sh_ops[o] != OP_NIB_SWAP) begin
          exp_sr[`BFE_SR_C] = r[8];
          exp_sr[`BFE_SR_Z] = (r[7:0] == 8'h00);
          exp_sr[`BFE_SR_N] = r[7];
          exp_sr[`BFE_SR_V] = r[7] ^ r[8];
        end
        run_op(sh_ops[o], 5'h03, 3'h0, 6'h00, 7'h00, 0);
        pk_rd(7'h03);
        `CHK("shift result", r[7:0], rd_val)
      end
    end
  endtask

  task automatic t_bits();
    pk_wr(7'h04, 8'h10);
    exp_sr[`BFE_SR_T] = 1'b1;
    run_op(OP_BIT_TO_XFER, 5'h04, 3'h4, 6'h00, 7'h00, 0);
    exp_sr[`BFE_SR_T] = 1'b0;
    run_op(OP_BIT_TO_XFER, 5'h04, 3'h0, 6'h00, 7'h00, 0);
    pk_wr(7'h05, 8'hFF);
    run_op(OP_XFER_TO_BIT, 5'h05, 3'h7, 6'h00, 7'h00, 0);
    pk_rd(7'h05);
    `CHK("bit load zero", 8'h7F, rd_val)
    set_flag(`BFE_SR_T, 1'b1);
    pk_wr(7'h05, 8'h00);
    run_op(OP_XFER_TO_BIT, 5'h05, 3'h2, 6'h00, 7'h00, 0);
    pk_rd(7'h05);
    `CHK("bit load one", 8'h04, rd_val)
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    #(100 * 8000);
    bad_count++;
    final_report();
  end

  initial begin
    bad_count   = 0;
    num_checks  = 0;
    exp_pc      = `BFE_PC_RESET;
    exp_sr      = `BFE_SR_RESET;
    resetn      = 1'b0;
    instr_valid = 1'b0;
    instr       = '0;
    peek_addr   = 7'h00;
    peek_wdata  = 8'h00;
    peek_wr     = 1'b0;
    peek_rd     = 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_flags();
    t_branch();
    t_io();
    t_shift();
    t_bits();
    final_report();
  end

endmodule
